// ### hdl/intc_pkg.sv
// Constants, field layouts and register offsets of the prioritised interrupt and event transfer controller.
// Assumes a single 100 MHz system clock and byte addresses on an AXI4-Lite bus with 32-bit data.
package intc_pkg;
   localparam int NODES = 16;
   localparam int EXT = 6;
   localparam int CHANS = 8;
   localparam int PRIO_W = 4;
   localparam int NODE_IDX_W = 4;
   localparam int CH_IDX_W = 3;
   localparam int PTR_W = 24;
   localparam int CNT_W = 8;
   localparam int TRAP_W = 7;
   localparam int VEC_W = 16;
   localparam int ST_W = 3;
   localparam int AXI_AW = 8;
   // Node control word
   localparam int PRIO_LSB = 0;
   localparam int EN_BIT = 6;
   localparam int PEND_BIT = 7;
   localparam int ROUTE_BIT = 8;
   localparam int CHSEL_LSB = 9;
   localparam int NODE_CTRL_W = 12;
   // Channel control word
   localparam int CNT_LSB = 0;
   localparam int WORD_BIT = 8;
   localparam int INCS_BIT = 9;
   localparam int INCD_BIT = 10;
   localparam int CONT_BIT = 11;
   localparam int CHCTL_W = 12;
   // Sticky status bits
   localparam int ST_XFER = 0;
   localparam int ST_FINAL = 1;
   localparam int ST_TRAP = 2;
   localparam logic [TRAP_W-1:0] TRAP_BASE = 7'h18;
   localparam logic [AXI_AW-1:0] OFS_NODE = 8'h00;
   localparam logic [AXI_AW-1:0] OFS_CHAN = 8'h40;
   localparam logic [AXI_AW-1:0] OFS_EDGE = 8'hC0;
   localparam logic [AXI_AW-1:0] OFS_STATUS = 8'hC4;
   localparam logic [AXI_AW-1:0] OFS_MASK = 8'hC8;
   localparam logic [AXI_AW-1:0] OFS_ENGINE = 8'hCC;
   localparam logic [1:0] CH_SRC = 2'h0;
   localparam logic [1:0] CH_DST = 2'h1;
   localparam logic [1:0] CH_CTL = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [PTR_W-1:0] BYTE_STEP = 24'h000001;
   localparam logic [PTR_W-1:0] WORD_STEP = 24'h000002;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   typedef enum logic [1:0] {ENG_IDLE, ENG_OFFER} eng_t;
endpackage : intc_pkg

// ### hdl/intc_top.sv
// Interrupt node arbitration, vectoring, software traps and eight event transfer channels, with an AXI4-Lite slave.
// Assumes the CPU reports its running service level and accepts an offered interrupt with a one-cycle ack.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Each node has pending, enable, priority fields
// - Priority field selects one of sixteen levels
// - Preempt only for strictly higher priority
// - Each node vectors to its own location
// - Each node routes to interrupt or transfer
// - Transfer takes one cycle, no vector
// - Transfer moves byte/word, bumps chosen pointers
// - Counter decrements per transfer, except continuous
// - Counter zero raises the node's interrupt
// - Eight channels, own pointers and counter
// - Fast inputs detect rise, fall or both
// - Software trap vectors to its number
// - Software-set pending flag raises an interrupt
// - Response well within about eight clocks
// - Fast inputs use traps 18h..1Dh, vectors 60h..74h
module intc_top
   import intc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [EXT-1:0] ext_irq,
   input wire logic [NODES-1:EXT] periph_req,
   input wire logic [PRIO_W-1:0] cpu_prio,
   input wire logic irq_ack,
   input wire logic trap_valid,
   input wire logic [TRAP_W-1:0] trap_num,
   output logic irq_req,
   output logic [VEC_W-1:0] irq_vec,
   output logic [TRAP_W-1:0] irq_trap,
   output logic [PRIO_W-1:0] irq_lvl,
   output logic xfer_valid,
   output logic [PTR_W-1:0] xfer_src,
   output logic [PTR_W-1:0] xfer_dst,
   output logic xfer_word,
   output logic sw_valid,
   output logic [VEC_W-1:0] sw_vec,
   output logic int_out,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   typedef struct packed {
      logic [NODES-1:0][NODE_CTRL_W-1:0] node;
      logic [CHANS-1:0][PTR_W-1:0] src;
      logic [CHANS-1:0][PTR_W-1:0] dst;
      logic [CHANS-1:0][CHCTL_W-1:0] chctl;
      logic [2*EXT-1:0] edge_cfg;
      logic [EXT-1:0] ext_prev;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      eng_t eng;
      logic [NODE_IDX_W-1:0] gnode;
      logic irq_req;
      logic [VEC_W-1:0] irq_vec;
      logic [TRAP_W-1:0] irq_trap;
      logic [PRIO_W-1:0] irq_lvl;
      logic xfer_valid;
      logic [PTR_W-1:0] xfer_src;
      logic [PTR_W-1:0] xfer_dst;
      logic xfer_word;
      logic sw_valid;
      logic [VEC_W-1:0] sw_vec;
      logic int_out;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic [NODES-1:0] elig;
   logic found;
   logic [NODE_IDX_W-1:0] best;
   logic [PRIO_W-1:0] best_prio;
   logic [NODE_CTRL_W-1:0] wctl;
   logic [CH_IDX_W-1:0] wch;
   logic [CHCTL_W-1:0] wchctl;
   logic do_xfer;
   logic [EXT-1:0] ext_set;
   logic [NODES-1:0] pend_set;
   logic [NODES-1:0] pend_clr;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;
   logic [32:0] rd_old;
   logic [31:0] bmask;
   logic [31:0] merged;
   logic [AXI_AW-1:0] coff;

   // Register read decode: bit 32 flags a mapped address
   function automatic logic [32:0] reg_read(input state_t st, input logic [AXI_AW-1:0] a);
      logic [AXI_AW-1:0] co;
      logic [32:0] r;
      co = a - OFS_CHAN;
      r = '0;
      if (a < OFS_CHAN) begin
         r = {1'b1, 20'h00000, st.node[a[5:2]]};
      end else if (a < OFS_EDGE) begin
         case (co[3:2])
            CH_SRC: r = {1'b1, 8'h00, st.src[co[6:4]]};
            CH_DST: r = {1'b1, 8'h00, st.dst[co[6:4]]};
            CH_CTL: r = {1'b1, 20'h00000, st.chctl[co[6:4]]};
            default: r = '0;
         endcase
      end else if (a == OFS_EDGE) begin
         r = {1'b1, 20'h00000, st.edge_cfg};
      end else if (a == OFS_STATUS) begin
         r = {1'b1, 29'h00000000, st.status};
      end else if (a == OFS_MASK) begin
         r = {1'b1, 29'h00000000, st.mask};
      end else if (a == OFS_ENGINE) begin
         r = {1'b1, 22'h000000, st.eng, st.gnode, st.irq_lvl};
      end
      return r;
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Arbitration over pending, enabled nodes
   always_comb begin
      {elig, found, best, best_prio} = '0;
      for (int i = 0; i < NODES; i++) begin
         elig[i] = s_r.node[i][PEND_BIT] && s_r.node[i][EN_BIT] &&
                   (s_r.node[i][PRIO_LSB +: PRIO_W] > cpu_prio);
         if (elig[i] && (!found || s_r.node[i][PRIO_LSB +: PRIO_W] > best_prio)) begin
            found = 1'b1;
            best = NODE_IDX_W'(i);
            best_prio = s_r.node[i][PRIO_LSB +: PRIO_W];
         end
      end
      wctl = s_r.node[best];
      wch = wctl[CHSEL_LSB +: CH_IDX_W];
      wchctl = s_r.chctl[wch];
      // zero count falls back to vector
      do_xfer = wctl[ROUTE_BIT] && (wchctl[CONT_BIT] || (wchctl[CNT_LSB +: CNT_W] != '0));
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_nxt = s_r;
      {ext_set, pend_set, pend_clr, st_set, st_clr, rd_old, bmask, merged, coff} = '0;
      if (ce) begin
         s_nxt.xfer_valid = 1'b0;
         s_nxt.sw_valid = 1'b0;
         for (int i = 0; i < EXT; i++) begin
            ext_set[i] = (ext_irq[i] && !s_r.ext_prev[i] && s_r.edge_cfg[2*i]) ||
                         (!ext_irq[i] && s_r.ext_prev[i] && s_r.edge_cfg[2*i+1]);
         end
         s_nxt.ext_prev = ext_irq;
         pend_set = {periph_req, ext_set};
         // Write channel: address and data taken in either order
         if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
            s_nxt.awready = 1'b0;
         end
         if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
            s_nxt.wready = 1'b0;
         end
         if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
         end
         if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            rd_old = reg_read(s_r, s_r.awaddr);
            for (int b = 0; b < 4; b++) begin
               bmask[8*b +: 8] = {8{s_r.wstrb[b]}};
            end
            merged = (rd_old[31:0] & ~bmask) | (s_r.wdata & bmask);
            coff = s_r.awaddr - OFS_CHAN;
            if (s_r.awaddr < OFS_CHAN) begin
               s_nxt.node[s_r.awaddr[5:2]] = merged[NODE_CTRL_W-1:0];
            end else if (s_r.awaddr < OFS_EDGE) begin
               case (coff[3:2])
                  CH_SRC: s_nxt.src[coff[6:4]] = merged[PTR_W-1:0];
                  CH_DST: s_nxt.dst[coff[6:4]] = merged[PTR_W-1:0];
                  CH_CTL: s_nxt.chctl[coff[6:4]] = merged[CHCTL_W-1:0];
                  default: s_nxt.chctl = s_nxt.chctl;
               endcase
            end else if (s_r.awaddr == OFS_EDGE) begin
               s_nxt.edge_cfg = merged[2*EXT-1:0];
            end else if (s_r.awaddr == OFS_MASK) begin
               s_nxt.mask = merged[ST_W-1:0];
            end
            s_nxt.bresp = rd_old[32] ? RESP_OKAY : RESP_SLVERR;
            s_nxt.bvalid = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
         end
         // Read channel; reading status clears it
         if (s_axi_arvalid && s_r.arready) begin
            rd_old = reg_read(s_r, s_axi_araddr);
            s_nxt.rdata = rd_old[31:0];
            s_nxt.rresp = rd_old[32] ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rvalid = 1'b1;
            s_nxt.arready = 1'b0;
            if (s_axi_araddr == OFS_STATUS) begin
               st_clr = '1;
            end
         end
         if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
         end
         // Service engine
         case (s_r.eng)
            ENG_IDLE: begin
               if (trap_valid) begin
                  s_nxt.sw_valid = 1'b1;
                  s_nxt.sw_vec = {7'h00, trap_num, 2'h0};
                  st_set[ST_TRAP] = 1'b1;
               end else if (found && do_xfer) begin
                  s_nxt.xfer_valid = 1'b1;
                  s_nxt.xfer_src = s_r.src[wch];
                  s_nxt.xfer_dst = s_r.dst[wch];
                  s_nxt.xfer_word = wchctl[WORD_BIT];
                  if (wchctl[INCS_BIT]) s_nxt.src[wch] = s_r.src[wch] + (wchctl[WORD_BIT] ? WORD_STEP : BYTE_STEP);
                  if (wchctl[INCD_BIT]) s_nxt.dst[wch] = s_r.dst[wch] + (wchctl[WORD_BIT] ? WORD_STEP : BYTE_STEP);
                  if (!wchctl[CONT_BIT]) begin
                     s_nxt.chctl[wch][CNT_LSB +: CNT_W] = wchctl[CNT_LSB +: CNT_W] - CNT_ONE;
                  end
                  pend_clr[best] = 1'b1;
                  st_set[ST_XFER] = 1'b1;
                  if (!wchctl[CONT_BIT] && wchctl[CNT_LSB +: CNT_W] == CNT_ONE) begin
                     pend_set[best] = 1'b1;
                     st_set[ST_FINAL] = 1'b1;
                  end
               end else if (found) begin
                  s_nxt.irq_req = 1'b1;
                  s_nxt.gnode = best;
                  s_nxt.irq_trap = TRAP_BASE + TRAP_W'(best);
                  s_nxt.irq_vec = {7'h00, TRAP_BASE + TRAP_W'(best), 2'h0};
                  s_nxt.irq_lvl = best_prio;
                  s_nxt.eng = ENG_OFFER;
               end
            end
            ENG_OFFER: begin
               if (irq_ack) begin
                  pend_clr[s_r.gnode] = 1'b1;
                  s_nxt.irq_req = 1'b0;
                  s_nxt.eng = ENG_IDLE;
               end
            end
            default: s_nxt.eng = ENG_IDLE;
         endcase
         // Hardware set wins over any clear or write
         for (int i = 0; i < NODES; i++) begin
            s_nxt.node[i][PEND_BIT] = (s_nxt.node[i][PEND_BIT] && !pend_clr[i]) || pend_set[i];
         end
         s_nxt.status = (s_r.status & ~st_clr) | st_set;
         s_nxt.int_out = |(s_nxt.status & s_nxt.mask);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign irq_req = s_r.irq_req;
   assign irq_vec = s_r.irq_vec;
   assign irq_trap = s_r.irq_trap;
   assign irq_lvl = s_r.irq_lvl;
   assign xfer_valid = s_r.xfer_valid;
   assign xfer_src = s_r.xfer_src;
   assign xfer_dst = s_r.xfer_dst;
   assign xfer_word = s_r.xfer_word;
   assign sw_valid = s_r.sw_valid;
   assign sw_vec = s_r.sw_vec;
   assign int_out = s_r.int_out;
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rvalid = s_r.rvalid;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_offer_holds: assert property (irq_req && !(ce && irq_ack) |=> irq_req && $stable(irq_vec))
      else $error("offered vector dropped or changed before ack");
   a_vector_map: assert property (irq_req |-> irq_vec == {7'h00, irq_trap, 2'h0} && irq_trap >= TRAP_BASE)
      else $error("vector does not match trap number");
   a_strict_preempt: assert property ($rose(irq_req) |-> irq_lvl > $past(cpu_prio))
      else $error("offered level not above running level");
   a_ack_release: assert property (irq_req && irq_ack && ce |=> !irq_req)
      else $error("offer not released after ack");
   a_xfer_no_vector: assert property (xfer_valid |-> !irq_req && !$past(irq_req))
      else $error("transfer overlapped a vector offer");
   a_trap_vector: assert property (ce && trap_valid && s_r.eng == ENG_IDLE |=> sw_valid && sw_vec == $past({7'h00, trap_num, 2'h0}))
      else $error("software trap vector wrong");
   a_rise_edge: assert property (ce && ext_irq[0] && !s_r.ext_prev[0] && s_r.edge_cfg[0] |=> s_r.node[0][PEND_BIT])
      else $error("rising edge did not set pending flag");
   a_idle_nothing: assert property (ce && elig == '0 && !trap_valid && s_r.eng == ENG_IDLE |=> !irq_req && !xfer_valid)
      else $error("service started with nothing eligible");
   a_count_down: assert property (ce && s_r.eng == ENG_IDLE && !trap_valid && found && do_xfer && wch == '0 &&
                                  !wchctl[CONT_BIT] && !s_r.aw_got
                                  |=> s_r.chctl[0][CNT_LSB +: CNT_W] == $past(s_r.chctl[0][CNT_LSB +: CNT_W]) - CNT_ONE)
      else $error("channel count not decremented");
   a_fast_response: assert property (ce && found && !do_xfer && !trap_valid && s_r.eng == ENG_IDLE |=> irq_req)
      else $error("eligible request not offered next cycle");

   c_vector_ack: cover property (irq_req && irq_ack && ce);
   c_transfer: cover property (xfer_valid);
   c_final_transfer: cover property (s_r.status[ST_FINAL] && int_out);
   c_sw_trap: cover property (sw_valid);

endmodule : intc_top

// ### tb/cpu_model.sv
// CPU side model: accepts interrupt offers and reports the level of the running service.
// Assumes an offer stands until acknowledged; the bench sets the ack delay and service length.
`timescale 1ns/10ps
module cpu_model
   import intc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_req,
   input wire logic [PRIO_W-1:0] irq_lvl,
   input wire logic [1:0] ack_dly,
   input wire logic [PRIO_W-1:0] base_lvl,
   input wire logic [7:0] svc_len,
   output logic irq_ack,
   output logic [PRIO_W-1:0] cpu_prio
);
   logic [1:0] wait_r;
   logic [7:0] busy_r;
   logic [PRIO_W-1:0] lvl_r;
   // Accepted service runs at its own level for svc_len cycles
   assign cpu_prio = (busy_r != 8'h00) ? lvl_r : base_lvl;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ack <= 1'b0;
         wait_r <= 2'h0;
         busy_r <= 8'h00;
         lvl_r <= 4'h0;
      end else if (irq_ack) begin
         irq_ack <= 1'b0;
         wait_r <= 2'h0;
         busy_r <= svc_len;
         lvl_r <= irq_lvl;
      end else begin
         if (irq_req && wait_r == ack_dly) irq_ack <= 1'b1;
         else if (irq_req) wait_r <= wait_r + 2'h1;
         if (busy_r != 8'h00) busy_r <= busy_r - 8'h01;
      end
   end
endmodule : cpu_model

// ### tb/tb_prioritized_interrupt_and_event_transfer.sv
// Self-checking bench: AXI4-Lite master, peripheral, pin and trap stimulus for the controller.
// Assumes cpu_model acknowledges offers; expectations come from the bench's own reference state.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_prioritized_interrupt_and_event_transfer
   import intc_pkg::*;
;
   logic aclk, aresetn, ce, irq_ack, trap_valid, irq_req, xfer_valid, xfer_word, sw_valid, int_out;
   logic [EXT-1:0] ext_irq;
   logic [NODES-1:EXT] periph_req;
   logic [PRIO_W-1:0] cpu_prio, irq_lvl, base_lvl;
   logic [TRAP_W-1:0] trap_num, irq_trap;
   logic [VEC_W-1:0] irq_vec, sw_vec;
   logic [PTR_W-1:0] xfer_src, xfer_dst, src_m, dst_m;
   logic [1:0] ack_dly, s_axi_bresp, s_axi_rresp;
   logic [7:0] svc_len;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int num_errors = 0;
   int checked = 0;
   intc_top DUT (.*);
   cpu_model cpu (.*);
   always #5 aclk = ~aclk;
////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bvalid, 1'b1)
      `CHK(s_axi_bresp, er)
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rvalid, 1'b1)
      `CHK(s_axi_rdata, ev)
      `CHK(s_axi_rresp, er)
   endtask : rd
   function automatic logic [31:0] nc(input int p, input int f, input int ch);
      return 32'(p) | (32'(f) << 6) | (32'(ch) << 9);
   endfunction : nc
   task automatic wait_hi(input logic xf, input int lim);
      int k;
      k = 0;
      do begin
         @(posedge aclk);
         #1;
         k++;
      end while ((xf ? xfer_valid : irq_req) !== 1'b1 && k < lim);
   endtask : wait_hi
   task automatic quiet(input int c);
      repeat (c) begin
         @(posedge aclk);
         #1;
         `CHK(irq_req, 1'b0)
      end
   endtask : quiet
   task automatic exp_irq(input int n, input int p, input int lim);
      wait_hi(1'b0, lim);
      `CHK(irq_req, 1'b1)
      `CHK(irq_vec, VEC_W'((24 + n) * 4))
      `CHK(irq_trap, TRAP_W'(24 + n))
      `CHK(irq_lvl, PRIO_W'(p))
      repeat (20) if (irq_req === 1'b1) @(posedge aclk);
      #1;
   endtask : exp_irq
   task automatic exp_xfer(input logic w);
      wait_hi(1'b1, 8);
      `CHK(xfer_valid, 1'b1)
      `CHK(irq_req, 1'b0)
      `CHK(xfer_src, src_m)
      `CHK(xfer_dst, dst_m)
      `CHK(xfer_word, w)
      @(posedge aclk);
      #1;
      `CHK(xfer_valid, 1'b0)
   endtask : exp_xfer
   task automatic pulse(input logic [NODES-1:EXT] m);
      @(posedge aclk);
      periph_req <= m;
      @(posedge aclk);
      periph_req <= '0;
   endtask : pulse
////////////////////////////////////////////////////////////
   initial begin
      #400000;
      num_errors++;
      give_verdict();
   end
   initial begin
      int p, m, n;
      logic w;
      logic [1:0] f;
      logic [31:0] ctl;
      logic [7:0] a;
      logic [TRAP_W-1:0] tn;
      {aclk, aresetn, trap_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {ext_irq, periph_req, trap_num, ack_dly, base_lvl, svc_len} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'h1FC57EAC));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 32'h0, RESP_OKAY);
      rd(8'hD0, 32'h0, RESP_SLVERR);
      wr(8'hD0, 32'hFFFF, RESP_SLVERR);
      for (int i = 0; i < NODES; i++) begin
         p = 1 + $urandom % 15;
         @(posedge aclk);
         ack_dly <= 2'($urandom % 4);
         wr(8'(4 * i), nc(p, 3, 0), RESP_OKAY);
         exp_irq(i, p, 8);
         rd(8'(4 * i), nc(p, 1, 0), RESP_OKAY);
      end
      wr(8'h14, nc(3, 2, 0), RESP_OKAY);
      quiet(12);
      rd(8'h14, nc(3, 2, 0), RESP_OKAY);
      wr(8'h14, nc(3, 3, 0), RESP_OKAY);
      exp_irq(5, 3, 8);
      @(posedge aclk);
      svc_len <= 8'h28;
      wr(8'h28, nc(9, 1, 0), RESP_OKAY);
      wr(8'h2C, nc(11, 1, 0), RESP_OKAY);
      wr(8'h30, nc(10, 1, 0), RESP_OKAY);
      wr(8'h34, nc(9, 1, 0), RESP_OKAY);
      pulse(10'h0D0);
      exp_irq(12, 10, 8);
      quiet(10);
      pulse(10'h020);
      exp_irq(11, 11, 8);
      exp_irq(10, 9, 60);
      // Last service must not leave the CPU busy for later scenarios
      @(posedge aclk);
      svc_len <= 8'h00;
      exp_irq(13, 9, 60);
      for (int i = 0; i < EXT; i++) begin
         m = 1 + i % 3;
         wr(OFS_EDGE, 32'(m) << (2 * i), RESP_OKAY);
         wr(8'(4 * i), nc(2, 1, 0), RESP_OKAY);
         @(posedge aclk);
         ext_irq[i] <= 1'b1;
         if (m != 2) exp_irq(i, 2, 8);
         else quiet(8);
         @(posedge aclk);
         ext_irq[i] <= 1'b0;
         if (m != 1) exp_irq(i, 2, 8);
         else quiet(8);
      end
      wr(OFS_MASK, 32'h7, RESP_OKAY);
      for (int c = 0; c < CHANS; c++) begin
         n = 6 + c;
         w = 1'($urandom % 2);
         f = 2'($urandom % 4);
         ctl = 32'h2 | (32'(w) << 8) | (32'(f) << 9) | (32'(c == 7) << 11);
         src_m = 24'($urandom);
         dst_m = 24'($urandom);
         a = OFS_CHAN + 8'(16 * c);
         wr(a, 32'(src_m), RESP_OKAY);
         wr(a + 8'h4, 32'(dst_m), RESP_OKAY);
         wr(a + 8'h8, ctl, RESP_OKAY);
         wr(8'(4 * n), nc(4, 5, c), RESP_OKAY);
         repeat (2) begin
            pulse(10'h001 << c);
            exp_xfer(w);
            if (f[0]) src_m = src_m + (w ? 24'h000002 : 24'h000001);
            if (f[1]) dst_m = dst_m + (w ? 24'h000002 : 24'h000001);
         end
         if (c != 7) exp_irq(n, 4, 8);
         else quiet(8);
         rd(a, 32'(src_m), RESP_OKAY);
         rd(a + 8'h4, 32'(dst_m), RESP_OKAY);
         rd(a + 8'h8, ctl - ((c == 7) ? 32'h0 : 32'h2), RESP_OKAY);
         rd(8'(4 * n), nc(4, 5, c), RESP_OKAY);
         `CHK(int_out, 1'b1)
         rd(OFS_STATUS, (c == 7) ? 32'h1 : 32'h3, RESP_OKAY);
         @(posedge aclk);
         #1;
         `CHK(int_out, 1'b0)
      end
      for (int j = 0; j < 4; j++) begin
         wr(OFS_MASK, (j < 3) ? 32'h4 : 32'h0, RESP_OKAY);
         @(posedge aclk);
         tn = 7'($urandom);
         trap_valid <= 1'b1;
         trap_num <= tn;
         @(posedge aclk);
         trap_valid <= 1'b0;
         #1;
         `CHK(sw_valid, 1'b1)
         `CHK(sw_vec, {tn, 2'b00})
         repeat (2) @(posedge aclk);
         #1;
         `CHK(int_out, j < 3)
         rd(OFS_STATUS, 32'h4, RESP_OKAY);
      end
      // Clock enable low freezes all state, a trap then is lost
      @(posedge aclk);
      ce <= 1'b0;
      trap_valid <= 1'b1;
      @(posedge aclk);
      trap_valid <= 1'b0;
      #1;
      `CHK(sw_valid, 1'b0)
      @(posedge aclk);
      ce <= 1'b1;
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      give_verdict();
   end
endmodule : tb_prioritized_interrupt_and_event_transfer
